/* pkg/sdb4_map.svh */
// Constants for the separate-port double-rate burst-of-four SRAM link.
// Assumes one system clock; each clock cycle carries one data beat.
// What this block does
// (RL1) Write data taken on both input edges
// (RL2) Low write select starts a write
// (RL3) Deselected write port ignores data inputs
// (RL4) Two nibble masks gate x8 data
// (RL5) Byte masks gate lanes per beat
// (RL6) Masked lane keeps stored value
// (RL7) Shared address taken on true edge
// (RL8) Address width per variant, burst location
// (RL9) Four sub-arrays, one word each
// (RL10) Address ignored when port deselected
// (RL11) Read data on output clock edges
// (RL12) Read outputs float when port deselected
// (RL13) Low read select starts a read
// (RL14) Pending read finishes, then outputs float
// (RL15) Each read returns four sequential words
// (RL16) Accesses begin on true input edge
// (RL17) Free-running echo clock on output
// (RL18) PLL off gives single-cycle latency
// (RL19) First read beat after 1.5 or 1 cycles
// (RL20) Alternate read/write slots, four write beats
`ifndef SDB4_MAP_SVH
`define SDB4_MAP_SVH
`define SDB4_DATA_W 36
`define SDB4_ADDR_W 17
`define SDB4_LANES 4
`define SDB4_LANE_W 9
`define SDB4_NIBBLE_W 4
`define SDB4_NIBBLES 2
`define SDB4_BURST 4
`define SDB4_SUB_DEPTH (1 << `SDB4_ADDR_W)
// Beats from request to first read word: 1.5 cycles with PLL, 1 cycle without.
`define SDB4_LAT_PLL_ON 2'h3
`define SDB4_LAT_PLL_OFF 2'h2
`define SDB4_PLL_OFF_MAX_MHZ 167
`define SDB4_FIFO_DEPTH 16
`define SDB4_FIFO_W (`SDB4_DATA_W + `SDB4_LANES + `SDB4_NIBBLES)
`endif

/* pkg/sdb4_pkg.sv */
// Types shared by both ends, and the lane decoding used by the SRAM end.
// Assumes the constant header is on the include path.
`include "sdb4_map.svh"
package sdb4_pkg;
  typedef logic [`SDB4_DATA_W-1:0] sdb4_data_t;
  // (RL8) burst location address
  typedef logic [`SDB4_ADDR_W-1:0] sdb4_addr_t;
  typedef logic [`SDB4_LANES-1:0] sdb4_bmask_t;
  typedef logic [`SDB4_NIBBLES-1:0] sdb4_nmask_t;

  // Bit enables for one beat from the active-low masks.
  function automatic sdb4_data_t sdb4_lane_enable(input sdb4_bmask_t bw_n,
                                                  input sdb4_nmask_t nw_n);
    sdb4_data_t en;
    en = '0;
    if (`SDB4_DATA_W == 8) begin
      // (RL4) nibble lane gating
      for (int i = 0; i < `SDB4_NIBBLES; i++) begin
        en[i*`SDB4_NIBBLE_W +: `SDB4_NIBBLE_W] = {`SDB4_NIBBLE_W{~nw_n[i]}};
      end
    end else begin
      // (RL5) byte lane gating
      for (int i = 0; i < `SDB4_LANES; i++) begin
        if ((i + 1) * `SDB4_LANE_W <= `SDB4_DATA_W) begin
          en[i*`SDB4_LANE_W +: `SDB4_LANE_W] = {`SDB4_LANE_W{~bw_n[i]}};
        end
      end
    end
    return en;
  endfunction : sdb4_lane_enable
endpackage : sdb4_pkg

/* pkg/sdb4_if.sv */
// Pin bundle between the memory controller and the SRAM.
// Assumes both ends run on the same system clock.
interface sdb4_if;
  import sdb4_pkg::*;
  logic k_clk;
  logic c_clk;
  logic single_clock_mode;
  logic pll_disable_n;
  sdb4_addr_t address;
  logic read_port_select_n;
  logic write_port_select_n;
  sdb4_data_t d;
  sdb4_bmask_t byte_write_mask_n;
  sdb4_nmask_t nibble_write_mask_n;
  sdb4_data_t q;
  logic q_oe;
  logic echo_clock_out;

  modport sram (
    input k_clk, c_clk, single_clock_mode, pll_disable_n, address,
    input read_port_select_n, write_port_select_n, d,
    input byte_write_mask_n, nibble_write_mask_n,
    output q, q_oe, echo_clock_out
  );
  modport ctrl (
    output k_clk, c_clk, single_clock_mode, pll_disable_n, address,
    output read_port_select_n, write_port_select_n, d,
    output byte_write_mask_n, nibble_write_mask_n,
    input q, q_oe, echo_clock_out
  );
endinterface : sdb4_if

/* core/sdb4_sram.sv */
// SRAM end: four sub-arrays, burst-of-four reads and masked writes.
// Assumes k_clk high marks a true-clock beat; every clock is one beat.
`include "sdb4_map.svh"
module sdb4_sram
  import sdb4_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  sdb4_if.sram lk
);
  // (RL9) four sub-arrays, one address reaches a word in each
  sdb4_data_t mem [`SDB4_BURST][`SDB4_SUB_DEPTH];

  logic wr_active;
  logic [1:0] wr_beat;
  sdb4_addr_t wr_addr;
  logic pend_valid;
  logic [1:0] pend_cnt;
  sdb4_addr_t pend_addr;
  logic rd_active;
  logic [1:0] rd_beat;
  sdb4_addr_t rd_addr;
  sdb4_data_t q;
  logic q_oe;
  logic echo_clock_out;

  // (RL16) accesses start on the true edge
  wire logic true_edge = lk.k_clk;
  // (RL2) write start on low select
  wire logic wr_start = true_edge && !lk.write_port_select_n;
  // (RL13) read start on low select
  wire logic rd_start = true_edge && !lk.read_port_select_n;
  // (RL18) latency follows the PLL mode
  wire logic [1:0] rd_lat = lk.pll_disable_n ? `SDB4_LAT_PLL_ON : `SDB4_LAT_PLL_OFF;
  wire logic launch = pend_valid && pend_cnt == 2'h0;
  // (RL3) data ignored unless a write is running
  wire logic wr_now = wr_start || wr_active;
  // (RL10) address only taken with its own select
  wire sdb4_addr_t wr_at = wr_start ? lk.address : wr_addr;
  wire logic [1:0] wr_sub = wr_start ? 2'h0 : wr_beat;
  // (RL6) masked lanes keep stored bits
  wire sdb4_data_t wr_en = sdb4_lane_enable(lk.byte_write_mask_n, lk.nibble_write_mask_n);
  wire logic rd_more = rd_active && rd_beat != 2'h0;
  wire sdb4_addr_t out_at = launch ? pend_addr : rd_addr;
  wire logic [1:0] out_sub = launch ? 2'h0 : rd_beat;

  // (RL1) one data beat per input edge
  always_ff @(posedge mclk) begin
    if (wr_now) begin
      mem[wr_sub][wr_at] <= (mem[wr_sub][wr_at] & ~wr_en) | (lk.d & wr_en);
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      wr_active <= 1'b0;
      wr_beat <= 2'h0;
      wr_addr <= '0;
    end else if (wr_start) begin
      // (RL7) write address on true edge
      wr_active <= 1'b1;
      wr_beat <= 2'h1;
      wr_addr <= lk.address;
    end else if (wr_active) begin
      wr_beat <= wr_beat + 2'h1;
      wr_active <= wr_beat != 2'h3;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pend_valid <= 1'b0;
      pend_cnt <= 2'h0;
      pend_addr <= '0;
    end else if (rd_start) begin
      // (RL19) first word launched rd_lat beats after the request, on q one beat later
      pend_valid <= 1'b1;
      pend_cnt <= rd_lat - 2'h1;
      pend_addr <= lk.address;
    end else if (launch) begin
      pend_valid <= 1'b0;
    end else if (pend_valid) begin
      pend_cnt <= pend_cnt - 2'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rd_active <= 1'b0;
      rd_beat <= 2'h0;
      rd_addr <= '0;
      q <= '0;
      q_oe <= 1'b0;
    end else begin
      // (RL15) four sequential words per read
      if (launch) begin
        rd_addr <= pend_addr;
      end
      rd_active <= launch || rd_more;
      rd_beat <= (launch || rd_more) ? out_sub + 2'h1 : 2'h0;
      // (RL11) one word launched per output edge
      q <= (launch || rd_more) ? mem[out_sub][out_at] : '0;
      // (RL12) outputs float when idle
      // (RL14) a pending burst completes first
      q_oe <= launch || rd_more;
    end
  end

  // (RL17) echo clock follows output or input clock
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      echo_clock_out <= 1'b0;
    end else begin
      echo_clock_out <= lk.single_clock_mode ? lk.k_clk : lk.c_clk;
    end
  end

  assign lk.q = q;
  assign lk.q_oe = q_oe;
  assign lk.echo_clock_out = echo_clock_out;
endmodule : sdb4_sram

/* core/sdb4_ctrl.sv */
// Controller end: write data FIFO, command slots and read capture.
// Assumes the SRAM samples on the same clock and k_clk marks true edges.
`include "sdb4_map.svh"
module sdb4_fifo #(
  parameter int WIDTH = `SDB4_FIFO_W,
  parameter int DEPTH = `SDB4_FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] count
);
  logic [WIDTH-1:0] store [DEPTH];
  logic [$clog2(DEPTH)-1:0] wr_ptr;
  logic [$clog2(DEPTH)-1:0] rd_ptr;
  wire logic push = in_valid && in_ready;
  wire logic pop = out_valid && out_ready;
  wire logic [$clog2(DEPTH):0] next_count = count + {{$clog2(DEPTH){1'b0}}, push}
                                            - {{$clog2(DEPTH){1'b0}}, pop};

  assign out_data = store[rd_ptr];

  // Pointer advance shared by both ends of the queue.
  function automatic logic [$clog2(DEPTH)-1:0] bump(input logic [$clog2(DEPTH)-1:0] ptr,
                                                   input logic en);
    return en ? ptr + {{($clog2(DEPTH)-1){1'b0}}, 1'b1} : ptr;
  endfunction : bump

  always_ff @(posedge mclk) begin
    if (push) begin
      store[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      wr_ptr <= bump(wr_ptr, push);
      rd_ptr <= bump(rd_ptr, pop);
      count <= next_count;
      in_ready <= next_count < DEPTH[$clog2(DEPTH):0];
      out_valid <= next_count != '0;
    end
  end
endmodule : sdb4_fifo

module sdb4_ctrl
  import sdb4_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic pll_off_req,
  input wire logic single_clock_req,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire sdb4_addr_t cmd_addr,
  output logic cmd_ready,
  input wire logic wdata_valid,
  input wire sdb4_data_t wdata,
  input wire sdb4_bmask_t wdata_byte_mask_n,
  input wire sdb4_nmask_t wdata_nibble_mask_n,
  output logic wdata_ready,
  output logic rdata_valid,
  output sdb4_data_t rdata,
  sdb4_if.ctrl lk
);
  logic k_clk;
  logic rd_slot;
  logic held;
  logic held_write;
  sdb4_addr_t held_addr;
  logic wr_active;
  logic [1:0] wr_beat;
  logic rps_n;
  logic wps_n;
  sdb4_addr_t addr;
  logic pll_n;
  logic single;
  logic fifo_pop;
  logic [`SDB4_FIFO_W-1:0] fifo_word;
  logic [$clog2(`SDB4_FIFO_DEPTH):0] fifo_count;
  logic fifo_out_valid;

  sdb4_fifo #(.WIDTH(`SDB4_FIFO_W), .DEPTH(`SDB4_FIFO_DEPTH)) u_wfifo (
    .mclk(mclk),
    .reset_n(reset_n),
    .in_valid(wdata_valid),
    .in_ready(wdata_ready),
    .in_data({wdata_nibble_mask_n, wdata_byte_mask_n, wdata}),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_word),
    .count(fifo_count)
  );

  // Next cycle carries the true edge; slots alternate between reads and writes.
  wire logic next_true = !k_clk;
  // (RL20) alternating slots, write waits for four beats
  wire logic fire_rd = next_true && rd_slot && held && !held_write;
  wire logic fire_wr = next_true && !rd_slot && held && held_write && !wr_active
                       && fifo_count >= ($clog2(`SDB4_FIFO_DEPTH) + 1)'(`SDB4_BURST);
  wire logic beat_out = fire_wr || wr_active;
  assign fifo_pop = beat_out;
  wire logic next_rd_slot = next_true ? !rd_slot : rd_slot;
  wire sdb4_addr_t next_addr = (fire_rd || fire_wr) ? held_addr : addr;

  // Clock phase, slot parity and mode pins run freely once out of reset.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      k_clk <= 1'b0;
      rd_slot <= 1'b0;
      pll_n <= 1'b1;
      single <= 1'b0;
    end else begin
      k_clk <= next_true;
      rd_slot <= next_rd_slot;
      pll_n <= !pll_off_req;
      single <= single_clock_req;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      held <= 1'b0;
      held_write <= 1'b0;
      held_addr <= '0;
      cmd_ready <= 1'b0;
    end else if (cmd_valid && cmd_ready) begin
      held <= 1'b1;
      held_write <= cmd_write;
      held_addr <= cmd_addr;
      cmd_ready <= 1'b0;
    end else if (fire_rd || fire_wr) begin
      held <= 1'b0;
      cmd_ready <= 1'b1;
    end else begin
      cmd_ready <= !held;
    end
  end

  // (RL7) address and selects on the true edge
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rps_n <= 1'b1;
      wps_n <= 1'b1;
      addr <= '0;
    end else begin
      rps_n <= !fire_rd;
      wps_n <= !fire_wr;
      addr <= next_addr;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      wr_active <= 1'b0;
      wr_beat <= 2'h0;
    end else begin
      wr_active <= fire_wr || (wr_active && wr_beat != 2'h3);
      wr_beat <= beat_out ? wr_beat + 2'h1 : 2'h0;
    end
  end

  // (RL1) one data beat per edge with its masks
  sdb4_data_t d;
  sdb4_bmask_t bw_n;
  sdb4_nmask_t nw_n;
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      d <= '0;
      bw_n <= '1;
      nw_n <= '1;
    end else begin
      d <= beat_out ? fifo_word[`SDB4_DATA_W-1:0] : '0;
      bw_n <= beat_out ? fifo_word[`SDB4_DATA_W +: `SDB4_LANES] : '1;
      nw_n <= beat_out ? fifo_word[`SDB4_DATA_W+`SDB4_LANES +: `SDB4_NIBBLES] : '1;
    end
  end

  // (RL19) read words taken whenever the SRAM drives them
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rdata_valid <= 1'b0;
      rdata <= '0;
    end else begin
      rdata_valid <= lk.q_oe;
      rdata <= lk.q_oe ? lk.q : '0;
    end
  end

  assign lk.k_clk = k_clk;
  assign lk.c_clk = k_clk;
  assign lk.single_clock_mode = single;
  assign lk.pll_disable_n = pll_n;
  assign lk.address = addr;
  assign lk.read_port_select_n = rps_n;
  assign lk.write_port_select_n = wps_n;
  assign lk.d = d;
  assign lk.byte_write_mask_n = bw_n;
  assign lk.nibble_write_mask_n = nw_n;
endmodule : sdb4_ctrl

/* verification/sidsbp_link_assertions.sv */
// Concurrent checks on the link between the controller and the SRAM.
// Assumes its inputs come straight from the link interface instance.
module sidsbp_link_checker
  import sdb4_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic k_clk,
  input wire logic c_clk,
  input wire logic single_clock_mode,
  input wire logic pll_disable_n,
  input wire logic read_port_select_n,
  input wire logic write_port_select_n,
  input wire sdb4_data_t q,
  input wire logic q_oe,
  input wire logic echo_clock_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  wire rd_take = k_clk & ~read_port_select_n;
  wire wr_take = k_clk & ~write_port_select_n;
  wire echo_src = single_clock_mode ? k_clk : c_clk;

  k_toggle_a: assert property ($past(reset_n) |-> k_clk != $past(k_clk))
    else $error("true clock phase did not alternate");
  true_edge_a: assert property (!read_port_select_n || !write_port_select_n |-> k_clk)
    else $error("select asserted on a complement edge");
  lat_pll_on_a: assert property (rd_take && pll_disable_n |-> ##4 q_oe [*4])
    else $error("read burst late or short with pll on");
  lat_pll_off_a: assert property (rd_take && !pll_disable_n |-> ##3 q_oe [*4])
    else $error("read burst late or short with pll off");
  burst_cause_a: assert property ($rose(q_oe) |-> $past(rd_take, 4) || $past(rd_take, 3))
    else $error("read data driven without a read request");
  burst_end_a: assert property ($rose(q_oe) ##4 1 |-> !q_oe || $past(rd_take, 4)
    || $past(rd_take, 3))
    else $error("read outputs not released after four words");
  q_idle_a: assert property (!q_oe |-> q == '0)
    else $error("read data not released while idle");
  echo_track_a: assert property ($past(reset_n) |-> echo_clock_out == $past(echo_src))
    else $error("echo clock does not follow its source");
  wr_gap_a: assert property (wr_take |=> write_port_select_n [*3])
    else $error("write requests closer than four beats");
  rd_gap_a: assert property (rd_take |=> read_port_select_n [*3])
    else $error("read requests closer than four beats");
  no_clash_a: assert property (!(rd_take && wr_take))
    else $error("read and write share one address slot");
endmodule : sidsbp_link_checker

/* verification/sep_io_ddr_sram_burst4_port_tb_top.sv */
// Self-checking bench: controller and SRAM joined over the link interface.
// Assumes the package, interface, design and checker are compiled first.
module sep_io_ddr_sram_burst4_port_tb_top
  import sdb4_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 1'b0, reset_n = 1'b0, pll_off_req = 1'b0, single_clock_req = 1'b0;
  logic cmd_valid = 1'b0, cmd_write = 1'b0, wdata_valid = 1'b0;
  logic cmd_ready, wdata_ready, rdata_valid;
  sdb4_addr_t cmd_addr = '0;
  sdb4_data_t wdata = '0;
  sdb4_data_t rdata, nw;
  sdb4_bmask_t wdata_byte_mask_n = 4'hF;
  sdb4_data_t e [4];
  sdb4_addr_t al [4] = '{17'h00001, 17'h1FFFF, 17'h0ABCD, 17'h10000};
  int n_fail = 0;
  int n_compared = 0;

  sdb4_if lk_if ();
  sdb4_ctrl sdb4_ctrl_i (.mclk, .reset_n, .pll_off_req, .single_clock_req, .cmd_valid,
    .cmd_write, .cmd_addr, .cmd_ready, .wdata_valid, .wdata, .wdata_byte_mask_n,
    .wdata_nibble_mask_n(2'h3), .wdata_ready, .rdata_valid, .rdata, .lk(lk_if.ctrl));
  sdb4_sram sdb4_sram_i (.mclk, .reset_n, .lk(lk_if.sram));
  sidsbp_link_checker sidsbp_link_checker_i (.mclk, .reset_n, .k_clk(lk_if.k_clk),
    .c_clk(lk_if.c_clk), .single_clock_mode(lk_if.single_clock_mode),
    .pll_disable_n(lk_if.pll_disable_n), .read_port_select_n(lk_if.read_port_select_n),
    .write_port_select_n(lk_if.write_port_select_n), .q(lk_if.q), .q_oe(lk_if.q_oe),
    .echo_clock_out(lk_if.echo_clock_out));

  always #2.5 mclk = ~mclk;

  task automatic check(input sdb4_data_t seen, input sdb4_data_t want);
    n_compared++;
    if (seen !== want) begin
      n_fail++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, want);
    end
  endtask : check

  function automatic sdb4_data_t pat(input sdb4_addr_t a, input int b, input logic [3:0] s);
    return {s, b[1:0], 13'h0A5C, a};
  endfunction : pat

  task automatic fill(input sdb4_addr_t a, input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      e[i] = pat(a, i, s);
    end
  endtask : fill

  // Pushes four beats in order, holding valid until each word is taken.
  task automatic push4(input sdb4_addr_t a, input logic [3:0] s, input logic [15:0] mk);
    wdata_valid <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wdata <= pat(a, i, s);
      wdata_byte_mask_n <= mk[i*4 +: 4];
      do @(posedge mclk); while (wdata_ready !== 1'b1);
    end
    wdata_valid <= 1'b0;
    @(posedge mclk);
  endtask : push4

  task automatic issue(input logic w, input sdb4_addr_t a);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_addr <= a;
    do @(posedge mclk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    @(posedge mclk);
  endtask : issue

  // Reads one burst and compares all four words against e.
  task automatic rd(input sdb4_addr_t a);
    int n;
    n = 0;
    issue(1'b0, a);
    while (rdata_valid !== 1'b1 && n < 40) begin
      @(posedge mclk);
      n++;
    end
    for (int i = 0; i < 4; i++) begin
      check(rdata, e[i]);
      check(sdb4_data_t'(rdata_valid), 36'h1);
      @(posedge mclk);
    end
    check(sdb4_data_t'(rdata_valid), 36'h0);
  endtask : rd

  task automatic test_done;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    push4(17'h00000, 4'h1, 16'h0000);
    issue(1'b1, 17'h00000);
    fill(17'h00000, 4'h1);
    rd(17'h00000);
    $display("test plain done");
    // Each beat writes only its own lane, so the other lanes keep old data.
    push4(17'h00000, 4'h2, 16'h7BDE);
    issue(1'b1, 17'h00000);
    for (int i = 0; i < 4; i++) begin
      nw = pat(17'h00000, i, 4'h2);
      e[i][i*9 +: 9] = nw[i*9 +: 9];
    end
    rd(17'h00000);
    $display("test mask done");
    for (int j = 0; j < 4; j++) begin
      push4(al[j], 4'h3, 16'h0000);
    end
    @(posedge mclk);
    check(sdb4_data_t'(wdata_ready), 36'h0);
    for (int j = 0; j < 4; j++) begin
      issue(1'b1, al[j]);
    end
    for (int j = 0; j < 4; j++) begin
      fill(al[j], 4'h3);
      rd(al[j]);
    end
    $display("test fifo done");
    pll_off_req <= 1'b1;
    single_clock_req <= 1'b1;
    repeat (4) @(posedge mclk);
    fill(al[1], 4'h3);
    rd(al[1]);
    $display("test pll off done");
    test_done;
  end

  initial begin
    repeat (3000) @(posedge mclk);
    n_fail++;
    test_done;
  end
endmodule : sep_io_ddr_sram_burst4_port_tb_top
